// ==== inc/alarm_pkg.sv ====
/*
  Constants shared by the driver failure and all-ones alarm block.
  Assumes a single 200 MHz system clock; per-channel transmit clocks and
  line status pins arrive asynchronously and are sampled on that clock.
*/
// Operation
// [R1] Flag goes high while that channel's transmit driver reports a short.
// [R2] Flag goes high after over 128 transmit clocks with no output pulse.
// [R3] Eight independent flags, each reflecting only its own channel.
// [R4] With auto all-ones enabled, a channel in loss of signal sends all ones; the code does so in hardware mode only.
// [R5] Substitution is per channel, from that channel's own loss of signal.
// [R6] With auto all-ones disabled, loss of signal never forces all ones.
// [R7] One shared enable governs all-ones substitution for all eight channels.
// [R8] In host mode the active-low interrupt output asserts on an alarm.
// [R9] Shared interrupt pin acts as interrupt only; no ratio select function.
// [R10] Global interrupt enable cleared to zero suppresses all interrupts.
// [R11] Each pulse restarts the missing-pulse count; flag clears when healthy.
package alarm_pkg;

  // ************************************************************
  // Sizes and timing
  // ************************************************************
  localparam int unsigned NUM_CHAN        = 8;
  localparam int unsigned MISS_PULSE_MAX  = 128;  // Transmit clock cycles
  localparam int unsigned MISS_CNT_W      = 8;
  localparam int unsigned SYNC_STAGES     = 3;

  // Reset values
  localparam logic        FLAG_RST        = 1'b0;
  localparam logic        IRQ_N_RST       = 1'b1;
  localparam logic [MISS_CNT_W-1:0] CNT_RST = 8'h00;

  // Monitor state per channel
  typedef enum logic [1:0] {
    MON_OK   = 2'b01,
    MON_FAIL = 2'b10
  } mon_state_e;

endpackage

// ==== design/chan_drv_monitor.sv ====
/*
  One channel's driver failure monitor.
  Assumes the transmit clock, the output pulse marker and the short
  indication are asynchronous to clock; each passes three flip-flops and
  a change counts only when stages two and three agree.
*/
`timescale 1ns/10ps
module chan_drv_monitor
  import alarm_pkg::*;
#(
  parameter int unsigned MISS_MAX = MISS_PULSE_MAX
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Line side, asynchronous
  input  wire logic chan_tx_clock,
  input  wire logic tx_pulse,
  input  wire logic drv_short,
  // Result
  output logic      fail_q
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [SYNC_STAGES-1:0] clk_sy_q, pls_sy_q, sht_sy_q;
  logic                   clk_st_q, pls_st_q, sht_st_q;

  // Three stage shift; stage one is read only by stage two
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_sy_q <= '0;
      pls_sy_q <= '0;
      sht_sy_q <= '0;
    end else begin
      clk_sy_q <= {clk_sy_q[1:0], chan_tx_clock};
      pls_sy_q <= {pls_sy_q[1:0], tx_pulse};
      sht_sy_q <= {sht_sy_q[1:0], drv_short};
    end
  end

  // Filtered levels move only when stages two and three agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_st_q <= 1'b0;
      pls_st_q <= 1'b0;
      sht_st_q <= 1'b0;
    end else begin
      if (clk_sy_q[1] == clk_sy_q[2]) clk_st_q <= clk_sy_q[2];
      if (pls_sy_q[1] == pls_sy_q[2]) pls_st_q <= pls_sy_q[2];
      if (sht_sy_q[1] == sht_sy_q[2]) sht_st_q <= sht_sy_q[2];
    end
  end

  // ************************************************************
  // Missing pulse counter
  // ************************************************************
  logic                  txclk_rise;
  logic                  pulse_seen_q;
  logic [MISS_CNT_W-1:0] miss_cnt_q;
  logic                  miss_q;
  logic                  clk_sy_d;

  assign clk_sy_d   = (clk_sy_q[1] == clk_sy_q[2]) ? clk_sy_q[2] : clk_st_q;
  assign txclk_rise = clk_sy_d & ~clk_st_q;

  // A pulse seen between transmit edges is held until the next edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pulse_seen_q <= 1'b0;
    end else if (txclk_rise) begin
      pulse_seen_q <= 1'b0;
    end else if (pls_st_q) begin
      pulse_seen_q <= 1'b1;
    end
  end

  // Counts transmit edges without a pulse; saturates so it never wraps
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      miss_cnt_q <= CNT_RST;
      miss_q     <= 1'b0;
    end else if (txclk_rise) begin
      if (pulse_seen_q || pls_st_q) begin
        miss_cnt_q <= CNT_RST;                          // R11
        miss_q     <= 1'b0;                             // R11
      end else if (miss_cnt_q < MISS_CNT_W'(MISS_MAX)) begin
        miss_cnt_q <= miss_cnt_q + 8'h01;
      end else begin
        miss_q <= 1'b1;                                 // R2
      end
    end
  end

  // ************************************************************
  // Failure state
  // ************************************************************
  mon_state_e state_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= MON_OK;
    end else begin
      case (state_q)
        MON_OK:   if (sht_st_q || miss_q) state_q <= MON_FAIL; // R1 R2
        MON_FAIL: if (!sht_st_q && !miss_q) state_q <= MON_OK; // R11
        default:  state_q <= MON_OK;
      endcase
    end
  end

  // Registered output straight from the state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fail_q <= FLAG_RST;
    end else begin
      fail_q <= (state_q == MON_FAIL);
    end
  end

endmodule // chan_drv_monitor

// ==== design/drv_fail_alarm.sv ====
/*
  Eight-channel driver failure monitor, automatic all-ones control and
  active-low alarm interrupt.
  Assumes line status pins are asynchronous; control pins host_mode,
  auto_all_ones_enable and global_irq_enable are static straps or come
  from host logic and are also synchronised here for safety.
*/
`timescale 1ns/10ps
module drv_fail_alarm
  import alarm_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CHAN,
  parameter int unsigned MISS_MAX = MISS_PULSE_MAX
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                reset_n,
  // Per-channel line status, asynchronous
  input  wire logic [CHANNELS-1:0] chan_tx_clock,
  input  wire logic [CHANNELS-1:0] tx_pulse,
  input  wire logic [CHANNELS-1:0] drv_short,
  input  wire logic [CHANNELS-1:0] loss_of_signal,
  // Mode and control
  input  wire logic                host_mode,
  input  wire logic                auto_all_ones_enable,
  input  wire logic                global_irq_enable,
  // Alarm outputs
  output logic      [CHANNELS-1:0] driver_fail_flag,
  output logic      [CHANNELS-1:0] send_all_ones,
  output logic                     alarm_irq_n,
  output logic                     alarm_irq_oe
);

  // ************************************************************
  // Per-channel monitors
  // ************************************************************
  logic [CHANNELS-1:0] fail_w;
  logic [CHANNELS-1:0] loss_st_q;

  // Each channel has its own monitor and its own loss filter
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    logic [SYNC_STAGES-1:0] loss_sy_q;

    chan_drv_monitor #(
      .MISS_MAX      (MISS_MAX)
    ) u_mon (
      .clock         (clock),
      .reset_n       (reset_n),
      .chan_tx_clock (chan_tx_clock[ch]),
      .tx_pulse      (tx_pulse[ch]),
      .drv_short     (drv_short[ch]),
      .fail_q        (fail_w[ch])                      // R3
    );

    // Loss of signal filter, same three stage scheme
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        loss_sy_q     <= '0;
        loss_st_q[ch] <= 1'b0;
      end else begin
        loss_sy_q <= {loss_sy_q[1:0], loss_of_signal[ch]};
        if (loss_sy_q[1] == loss_sy_q[2]) loss_st_q[ch] <= loss_sy_q[2];
      end
    end
  end

  // ************************************************************
  // Control pin synchronisers
  // ************************************************************
  logic [SYNC_STAGES-1:0] aao_sy_q, hm_sy_q, irqen_sy_q;
  logic                   aao_q, hm_q, irqen_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aao_sy_q <= '0;
      hm_sy_q  <= '0;
      irqen_sy_q <= '0;
      aao_q      <= 1'b0;
      hm_q       <= 1'b0;
      irqen_q    <= 1'b0;
    end else begin
      aao_sy_q <= {aao_sy_q[1:0], auto_all_ones_enable};
      hm_sy_q  <= {hm_sy_q[1:0], host_mode};
      irqen_sy_q <= {irqen_sy_q[1:0], global_irq_enable};
      if (aao_sy_q[1] == aao_sy_q[2]) aao_q <= aao_sy_q[2];
      if (hm_sy_q[1] == hm_sy_q[2])   hm_q  <= hm_sy_q[2];
      if (irqen_sy_q[1] == irqen_sy_q[2]) irqen_q <= irqen_sy_q[2];
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Flags pass straight through from each monitor
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      driver_fail_flag <= '0;
    end else begin
      driver_fail_flag <= fail_w;                       // R1 R2 R3
    end
  end

  // All-ones is a hardware mode feature; one shared enable for all
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      send_all_ones <= '0;
    end else if (aao_q && !hm_q) begin                  // R4 R6 R7
      send_all_ones <= loss_st_q;                       // R5
    end else begin
      send_all_ones <= '0;                              // R6
    end
  end

  // Open-drain interrupt: only ever pulls low, never ratio select
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alarm_irq_n  <= IRQ_N_RST;
      alarm_irq_oe <= 1'b0;
    end else begin
      alarm_irq_n  <= 1'b0;                             // R9
      alarm_irq_oe <= hm_q && irqen_q                   // R8 R10
                      && ((|fail_w) || (|loss_st_q));
    end
  end

endmodule // drv_fail_alarm

// ==== testbench/line_partner.sv ====
/*
  Line side model: free running transmit clocks and output pulses.
  Assumes the bench gates the pulses of each channel with pulse_en.
*/
`timescale 1ns/10ps
module line_partner (
  // Pulse gating
  input  wire logic [7:0] pulse_en,
  // Line side
  output logic      [7:0] chan_tx_clock,
  output wire logic [7:0] tx_pulse
);
  // ************************************************************
  // Transmit clocks
  // ************************************************************
  // Odd half periods keep channels unrelated and each phase over 3 clocks
  for (genvar i = 0; i < 8; i++) begin : g_ch
    initial chan_tx_clock[i] = 1'b0;
    always #(23 + 2 * i) chan_tx_clock[i] = ~chan_tx_clock[i];
  end
  // One pulse marker per transmit cycle, in its high phase
  assign tx_pulse = chan_tx_clock & pulse_en;
endmodule // line_partner

// ==== testbench/drv_fail_alarm_checker.sv ====
/*
  Port assertions for the alarm block.
  Assumes causes held 8 clocks are settled; latency is at most 8 clocks.
*/
`timescale 1ns/10ps
module drv_fail_alarm_checker #(
  parameter int unsigned CHANNELS = 8,
  parameter int unsigned MISS_MAX = 128
) (
  // Clock, causes and results
  input wire logic                clock, reset_n, host_mode,
  input wire logic                auto_all_ones_enable, global_irq_enable,
  input wire logic [CHANNELS-1:0] drv_short, loss_of_signal,
  input wire logic [CHANNELS-1:0] driver_fail_flag, send_all_ones,
  input wire logic                alarm_irq_n, alarm_irq_oe
);
  // ************************************************************
  // Level relations
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_ao;
    (!host_mode && auto_all_ones_enable && $stable(loss_of_signal))[*8]
      |-> send_all_ones == loss_of_signal;
  endproperty
  a_ao: assert property (p_ao) else $error("all ones wrong");
  property p_aoff;
    (!auto_all_ones_enable)[*8] |-> send_all_ones == '0;
  endproperty
  a_aoff: assert property (p_aoff) else $error("all ones on");
  property p_host;
    host_mode[*8] |-> send_all_ones == '0;
  endproperty
  a_host: assert property (p_host) else $error("all ones in host");
  // Short filter plus flag registers need up to 7 clocks; the property waits 10
  property p_short;
    $stable(drv_short)[*8] ##1 $stable(drv_short)[*2]
      |-> (driver_fail_flag & drv_short) == drv_short;
  endproperty
  a_short: assert property (p_short) else $error("short unflagged");
  property p_hwirq;
    (!host_mode)[*8] |-> !alarm_irq_oe;
  endproperty
  a_hwirq: assert property (p_hwirq) else $error("irq in hw mode");
  property p_irq_off;
    (!global_irq_enable)[*8] |-> !alarm_irq_oe;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq not masked");
  property p_irq;
    (host_mode && global_irq_enable && |loss_of_signal)[*8] |-> alarm_irq_oe;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_irqn;
    $past(reset_n, 2) |-> !alarm_irq_n;
  endproperty
  a_irqn: assert property (p_irqn) else $error("irq pin not low");
  c_ao: cover property (|send_all_ones);
  c_flag: cover property (|driver_fail_flag);
  c_irq: cover property (alarm_irq_oe);
endmodule // drv_fail_alarm_checker
bind drv_fail_alarm drv_fail_alarm_checker #(
  .CHANNELS             (CHANNELS),
  .MISS_MAX             (MISS_MAX)
) chk_u (
  .clock                (clock),
  .reset_n              (reset_n),
  .host_mode            (host_mode),
  .auto_all_ones_enable (auto_all_ones_enable),
  .global_irq_enable    (global_irq_enable),
  .drv_short            (drv_short),
  .loss_of_signal       (loss_of_signal),
  .driver_fail_flag     (driver_fail_flag),
  .send_all_ones        (send_all_ones),
  .alarm_irq_n          (alarm_irq_n),
  .alarm_irq_oe         (alarm_irq_oe)
);

// ==== testbench/drv_fail_alarm_tb_top.sv ====
/*
  Bench for the alarm block: random line status and modes, expected
  levels from an integer model. Assumes the line partner runs free.
*/
`timescale 1ns/10ps
module drv_fail_alarm_tb_top;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic       clock = 1'b0, reset_n = 1'b0, host_mode = 1'b0;
  logic       auto_all_ones_enable = 1'b0, global_irq_enable = 1'b0;
  logic [7:0] drv_short = 8'h00, loss_of_signal = 8'h00, pulse_en = 8'hff;
  wire logic [7:0] chan_tx_clock, tx_pulse, driver_fail_flag, send_all_ones;
  wire logic  alarm_irq_n, alarm_irq_oe;
  int         failures = 0, checks = 0, seed = 20698, i, ef = 0;
  // Short miss count keeps the missing-pulse wait brief
  drv_fail_alarm #(
    .MISS_MAX             (4)
  ) dut_u (
    .clock                (clock),
    .reset_n              (reset_n),
    .chan_tx_clock        (chan_tx_clock),
    .tx_pulse             (tx_pulse),
    .drv_short            (drv_short),
    .loss_of_signal       (loss_of_signal),
    .host_mode            (host_mode),
    .auto_all_ones_enable (auto_all_ones_enable),
    .global_irq_enable    (global_irq_enable),
    .driver_fail_flag     (driver_fail_flag),
    .send_all_ones        (send_all_ones),
    .alarm_irq_n          (alarm_irq_n),
    .alarm_irq_oe         (alarm_irq_oe)
  );
  line_partner ln_u (
    .pulse_en             (pulse_en),
    .chan_tx_clock        (chan_tx_clock),
    .tx_pulse             (tx_pulse)
  );
  always #2.5 clock = ~clock;
  // Inputs change 1 ns after the edge, away from sampling
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Model: the interrupt follows any loss or failure, it is not sticky
  task automatic check_all;
    int ea, ei;
    ea = (!host_mode && auto_all_ones_enable) ? loss_of_signal : 0;
    ei = host_mode && global_irq_enable && (loss_of_signal != 0 || ef != 0);
    check("all_ones", send_all_ones, ea[7:0]);
    check("flag", driver_fail_flag, ef[7:0]);
    check("irq_oe", {7'h00, alarm_irq_oe}, ei[7:0]);
    check("irq_n", {7'h00, alarm_irq_n}, 8'h00);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    step(6);
    check("rst_out", driver_fail_flag | send_all_ones, 8'h00);
    check("rst_irq", {6'h00, alarm_irq_n, alarm_irq_oe}, 8'h02);
    reset_n = 1'b1;
    step(20);
    // Every mode, enable and mask combination
    for (i = 0; i < 16; i++) begin
      host_mode = i[3];
      auto_all_ones_enable = i[0];
      global_irq_enable = i[1];
      loss_of_signal = i[2] ? 8'h00 : 8'($random(seed));
      step(12);
      check_all;
    end
    for (i = 0; i < 5; i++) begin
      drv_short = (i == 4) ? 8'h00 : 8'($random(seed));
      ef = drv_short;
      step(12);
      check_all;
    end
    // Slowest channel needs five tx edges of 74 ns each
    pulse_en = 8'($random(seed));
    // Concatenation keeps the inversion to eight bits
    ef = {24'h000000, ~pulse_en};
    step(120);
    check_all;
    pulse_en = 8'hff;
    ef = 0;
    step(40);
    check_all;
    // Mid-run reset returns every output to its reset value while the causes still stand
    drv_short = 8'($random(seed));
    loss_of_signal = 8'($random(seed)) | 8'h01;
    ef = drv_short;
    step(12);
    check_all;
    reset_n = 1'b0;
    step(2);
    check("mid_rst_out", driver_fail_flag | send_all_ones, 8'h00);
    check("mid_rst_irq", {6'h00, alarm_irq_n, alarm_irq_oe}, 8'h02);
    reset_n = 1'b1;
    step(20);
    check_all;
    conclude;
  end
  // Whole run is near 2.4 us
  initial begin
    #20000;
    failures++;
    conclude;
  end
endmodule // drv_fail_alarm_tb_top
